//--- port_field_preload.sv
// Preload of per-port switch fields from configuration memory words.
// Assumes words arrive already deserialised on this clock, and an APB
// master for status, control and read-back.
//
// The register addresses and the APB register port were chosen for this implementation.
module port_field_preload
    import preload_pkg::*;
#(
    parameter logic [11:0] DEF_REPLAY_LIMIT = 12'h100,
    parameter logic [13:0] DEF_ACK_LATENCY  = 14'h0100
) (
    input  wire logic                   CLOCK_IN,
    input  wire logic                   RST_B_IN,
    input  wire preload_word_t          WORD_IN,
    input  wire logic                   LOAD_DONE_IN,
    input  wire apb_req_t               APB_REQ_IN,
    output apb_rsp_t                    APB_RSP_OUT,
    output port_cfg_t [NPORT-1:0]       PORT_CFG_OUT,
    output logic [NPORT-1:0][11:0]      REPLAY_LIMIT_OUT,
    output logic [NPORT-1:0][13:0]      ACK_LATENCY_OUT,
    output logic [NPORT-1:0]            LINK_ENABLE_OUT
);

    typedef struct packed {
        bus_state_t            bus;
        logic                  sel_ctrl;
        logic                  sel_stat;
        logic                  sel_port;
        logic [1:0]            sel_pnum;
        logic [2:0]            sel_idx;
        apb_rsp_t              rsp;
        logic                  hold;
        logic                  done;
        logic                  late;
        logic [7:0]            words;
        logic [NPORT-1:0][11:0] replay_eff;
        logic [NPORT-1:0][13:0] ack_eff;
        logic [NPORT-1:0]      link_en;
    } top_t;

    top_t       st_r;
    top_t       st_nxt;
    field_wr_t  wr;
    field_rd_t  rd;
    logic [31:0] store_rd;
    logic [7:0] pmask;
    logic [2:0] wport;
    logic       word_hit;
    logic [11:0] pa;
    logic       is_ctrl;
    logic       is_stat;
    logic       is_port;
    logic [31:0] status_word;

    port_field_store u_store (
        .clk_in      (CLOCK_IN),
        .rst_b_in    (RST_B_IN),
        .wr_in       (wr),
        .rd_in       (rd),
        .rd_data_out (store_rd),
        .cfg_out     (PORT_CFG_OUT)
    );

    // ==================================================================
    // Word decode
    always_comb begin
        wr       = '0;
        pmask    = 8'h00;
        wport    = WORD_IN.addr[3:1];
        case (WORD_IN.addr[7:4])
            GRP_SLOT_LO: begin wr.kind = K_SLOT_LO; pmask = PORTS_SLOT; end
            GRP_SLOT_HI: begin wr.kind = K_SLOT_HI; pmask = PORTS_SLOT; end
            GRP_VEND_LO: begin wr.kind = K_VEND_LO; pmask = PORTS_ALL; end
            GRP_VEND_HI: begin wr.kind = K_VEND_HI; pmask = PORTS_ALL; end
            GRP_REPLAY:  begin wr.kind = K_REPLAY; pmask = PORTS_ALL; end
            GRP_ACK:     begin wr.kind = K_ACK; pmask = PORTS_ACK; end
            default:     begin wr.kind = K_NONE; pmask = 8'h00; end
        endcase
        word_hit = WORD_IN.valid && !WORD_IN.addr[0] && pmask[wport];
        // Words after completion are refused so running links never see a change
        wr.valid = word_hit && !st_r.done;
        wr.port  = wport[1:0];
        wr.data  = WORD_IN.data;
    end

    // ==================================================================
    // APB decode
    always_comb begin
        pa      = APB_REQ_IN.paddr;
        is_ctrl = (pa == A_CTRL);
        is_stat = (pa == A_STATUS);
        is_port = (pa[11:8] == A_PORT_PAGE) && !pa[7] && (pa[6:5] != 2'h3)
                  && (pa[4:2] < A_IDX_LIMIT) && (pa[1:0] == 2'h0);
        rd.valid = (st_r.bus == B_IDLE) && APB_REQ_IN.psel && !APB_REQ_IN.penable;
        rd.port  = pa[6:5];
        rd.idx   = pa[3:2];
        status_word = 32'h0000_0000;
        status_word[ST_DONE_BIT] = st_r.done;
        status_word[ST_BUSY_BIT] = (st_r.words != 8'h00) && !st_r.done;
        status_word[ST_LATE_BIT] = st_r.late;
        status_word[ST_COUNT_LSB +: 8] = st_r.words;
    end

    // ==================================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        case (st_r.bus)
            B_IDLE: begin
                if (rd.valid) begin
                    st_nxt.sel_ctrl = is_ctrl;
                    st_nxt.sel_stat = is_stat;
                    st_nxt.sel_port = is_port;
                    st_nxt.sel_pnum = pa[6:5];
                    st_nxt.sel_idx  = pa[4:2];
                    st_nxt.bus      = B_FETCH;
                end
            end
            B_FETCH: begin
                st_nxt.rsp.pready  = 1'b1;
                st_nxt.rsp.pslverr = !(st_r.sel_ctrl || st_r.sel_stat || st_r.sel_port);
                st_nxt.rsp.prdata  = 32'h0000_0000;
                if (st_r.sel_ctrl) begin
                    st_nxt.rsp.prdata[CTRL_HOLD_BIT] = st_r.hold;
                end else if (st_r.sel_stat) begin
                    st_nxt.rsp.prdata = status_word;
                end else if (st_r.sel_port) begin
                    if (!st_r.sel_idx[2]) begin
                        st_nxt.rsp.prdata = store_rd;
                    end else if (st_r.sel_idx == IDX_REPLAY) begin
                        st_nxt.rsp.prdata[11:0] = st_r.replay_eff[st_r.sel_pnum];
                    end else begin
                        st_nxt.rsp.prdata[13:0] = st_r.ack_eff[st_r.sel_pnum];
                    end
                end
                st_nxt.bus = B_DONE;
            end
            B_DONE: begin
                if (APB_REQ_IN.psel && APB_REQ_IN.penable) begin
                    if (APB_REQ_IN.pwrite && st_r.sel_ctrl && APB_REQ_IN.pstrb[0]) begin
                        st_nxt.hold = APB_REQ_IN.pwdata[CTRL_HOLD_BIT];
                        if (APB_REQ_IN.pwdata[CTRL_RELOAD_BIT]) begin
                            st_nxt.done  = 1'b0;
                            st_nxt.late  = 1'b0;
                            st_nxt.words = 8'h00;
                        end
                    end
                    st_nxt.rsp = '0;
                    st_nxt.bus = B_IDLE;
                end
            end
            default: begin
                st_nxt.rsp = '0;
                st_nxt.bus = B_IDLE;
            end
        endcase
        // Hardware events follow the software clear so that they win
        if (LOAD_DONE_IN) begin
            st_nxt.done = 1'b1;
        end
        if (word_hit && st_r.done) begin
            st_nxt.late = 1'b1;
        end
        if (wr.valid && (st_nxt.words != 8'hff)) begin
            st_nxt.words = st_nxt.words + 8'h01;
        end
        for (int p = 0; p < NPORT; p++) begin
            st_nxt.replay_eff[p] = PORT_CFG_OUT[p].timer_csr[REPLAY_USR_BIT]
                ? PORT_CFG_OUT[p].timer_csr[REPLAY_CNT_LSB +: REPLAY_CNT_W]
                : DEF_REPLAY_LIMIT;
            st_nxt.ack_eff[p] = PORT_CFG_OUT[p].timer_csr[ACK_USR_CBIT]
                ? PORT_CFG_OUT[p].timer_csr[ACK_CSR_LSB +: ACK_W]
                : DEF_ACK_LATENCY;
            st_nxt.link_en[p] = st_r.done && !st_r.hold;
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RST_B_IN) begin
            st_r <= '{bus: B_IDLE, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign APB_RSP_OUT      = st_r.rsp;
    assign REPLAY_LIMIT_OUT = st_r.replay_eff;
    assign ACK_LATENCY_OUT  = st_r.ack_eff;
    assign LINK_ENABLE_OUT  = st_r.link_en;

    // ==================================================================
    // Checks
    a_slot_lo_p1: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'h92 && !st_r.done
        |=> PORT_CFG_OUT[1].slot_cap[15:0] == $past(WORD_IN.data))
        else $error("slot low word of port 1 not loaded");

    a_slot_hi_p2: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'ha4 && !st_r.done
        |=> PORT_CFG_OUT[2].slot_cap[31:16] == $past(WORD_IN.data))
        else $error("slot high word of port 2 not loaded");

    a_vendor_low_p0: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'hb0 && !st_r.done
        |=> PORT_CFG_OUT[0].vendor_ctl[15:0] == $past(WORD_IN.data))
        else $error("vendor low half of port 0 not loaded");

    a_vendor_high_p2: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'hc4 && !st_r.done
        |=> PORT_CFG_OUT[2].vendor_ctl[31:16] == $past(WORD_IN.data))
        else $error("vendor high half of port 2 not loaded");

    a_replay_count: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'hd2 && !st_r.done
        |=> PORT_CFG_OUT[1].timer_csr[11:0] == $past(WORD_IN.data[11:0]))
        else $error("replay count of port 1 wrong");

    a_replay_user: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'hd0 && !st_r.done
        |=> PORT_CFG_OUT[0].timer_csr[12] == $past(WORD_IN.data[12]))
        else $error("replay enable of port 0 wrong");

    a_training_field: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'hd4 && !st_r.done
        |=> PORT_CFG_OUT[2].link_csr[25:24] == $past(WORD_IN.data[14:13]))
        else $error("training control field of port 2 wrong");

    a_ack_value: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'he0 && !st_r.done
        |=> PORT_CFG_OUT[0].timer_csr[29:16] == $past(WORD_IN.data[13:0]))
        else $error("ack latency of port 0 wrong");

    a_ack_user: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        WORD_IN.valid && WORD_IN.addr == 8'he2 && !st_r.done
        |=> PORT_CFG_OUT[1].timer_csr[30] == $past(WORD_IN.data[14]))
        else $error("ack enable of port 1 wrong");

    a_replay_select: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        RST_B_IN |=> REPLAY_LIMIT_OUT[0] == ($past(PORT_CFG_OUT[0].timer_csr[12])
            ? $past(PORT_CFG_OUT[0].timer_csr[11:0]) : DEF_REPLAY_LIMIT))
        else $error("effective replay limit of port 0 wrong");

    a_link_after_load: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        LINK_ENABLE_OUT[0] |-> $past(st_r.done) && !$past(st_r.hold))
        else $error("link enabled before load completed");

    a_frozen_after: assert property (@(posedge CLOCK_IN) disable iff (!RST_B_IN)
        st_r.done && !LOAD_DONE_IN |=> $stable(PORT_CFG_OUT))
        else $error("fields changed after load completed");

endmodule : port_field_preload

//--- preload_pkg.sv
// Shared constants and carriers for the per-port preload block.
// Assumes a single 200 MHz clock domain and an APB completer port.
// Notes on behaviour
// - Words 92h/94h fill slot capability low, ports 1/2
// - Words A2h/A4h fill slot capability high, ports 1/2
// - Words B0h-B4h fill vendor control low half
// - Words C0h-C4h fill vendor control high half
// - Words D0h-D4h bits 11:0 give replay count
// - Replay word bit 12 enables user replay value
// - Replay word bits 14:13 give training control field
// - Words E0h/E2h bits 13:0 give ack latency
// - Ack word bit 14 enables user latency value
package preload_pkg;

    // ==================================================================
    // Geometry
    localparam int NPORT = 3;

    // ==================================================================
    // Preload word address decode: group nibble, port in bits 3:1
    localparam logic [3:0] GRP_SLOT_LO = 4'h9;
    localparam logic [3:0] GRP_SLOT_HI = 4'ha;
    localparam logic [3:0] GRP_VEND_LO = 4'hb;
    localparam logic [3:0] GRP_VEND_HI = 4'hc;
    localparam logic [3:0] GRP_REPLAY  = 4'hd;
    localparam logic [3:0] GRP_ACK     = 4'he;
    localparam logic [7:0] PORTS_SLOT  = 8'h06;
    localparam logic [7:0] PORTS_ALL   = 8'h07;
    localparam logic [7:0] PORTS_ACK   = 8'h03;

    // ==================================================================
    // Field positions inside words and register images
    localparam int REPLAY_CNT_LSB = 0;
    localparam int REPLAY_CNT_W   = 12;
    localparam int REPLAY_USR_BIT = 12;
    localparam int TS_WORD_LSB    = 13;
    localparam int TS_CSR_LSB     = 24;
    localparam int TS_W           = 2;
    localparam int ACK_WORD_LSB   = 0;
    localparam int ACK_CSR_LSB    = 16;
    localparam int ACK_W          = 14;
    localparam int ACK_USR_WBIT   = 14;
    localparam int ACK_USR_CBIT   = 30;

    // ==================================================================
    // Reset values
    localparam logic [31:0] SLOT_RST  = 32'h0000_0000;
    localparam logic [31:0] VEND_RST  = 32'h0000_0000;
    localparam logic [31:0] TIMER_RST = 32'h0000_0000;
    localparam logic [31:0] LINK_RST  = 32'h0000_0000;

    // ==================================================================
    // APB map
    localparam logic [11:0] A_CTRL      = 12'h000;
    localparam logic [11:0] A_STATUS    = 12'h004;
    localparam logic [3:0]  A_PORT_PAGE = 4'h1;
    localparam logic [2:0]  A_IDX_LIMIT = 3'h6;
    localparam logic [2:0]  IDX_REPLAY  = 3'h4;
    localparam int CTRL_HOLD_BIT   = 0;
    localparam int CTRL_RELOAD_BIT = 1;
    localparam int ST_DONE_BIT     = 0;
    localparam int ST_BUSY_BIT     = 1;
    localparam int ST_LATE_BIT     = 2;
    localparam int ST_COUNT_LSB    = 8;

    // ==================================================================
    // Types
    typedef enum logic [5:0] {
        K_NONE    = 6'h00,
        K_SLOT_LO = 6'h01,
        K_SLOT_HI = 6'h02,
        K_VEND_LO = 6'h04,
        K_VEND_HI = 6'h08,
        K_REPLAY  = 6'h10,
        K_ACK     = 6'h20
    } word_kind_t;

    typedef enum logic [2:0] {
        B_IDLE  = 3'h1,
        B_FETCH = 3'h2,
        B_DONE  = 3'h4
    } bus_state_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [15:0] data;
    } preload_word_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] port;
        word_kind_t kind;
        logic [15:0] data;
    } field_wr_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] port;
        logic [1:0] idx;
    } field_rd_t;

    typedef struct packed {
        logic [31:0] slot_cap;
        logic [31:0] vendor_ctl;
        logic [31:0] timer_csr;
        logic [31:0] link_csr;
    } port_cfg_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } apb_rsp_t;

endpackage : preload_pkg

//--- port_field_store.sv
// Register images of the preloaded per-port fields with one read port.
// Assumes decoded writes from the loader and reads issued by the bus.
module port_field_store
    import preload_pkg::*;
(
    input  wire logic                  clk_in,
    input  wire logic                  rst_b_in,
    input  wire field_wr_t             wr_in,
    input  wire field_rd_t             rd_in,
    output logic      [31:0]           rd_data_out,
    output port_cfg_t [NPORT-1:0]      cfg_out
);

    typedef struct packed {
        port_cfg_t [NPORT-1:0] cfg;
        logic [31:0]           rd_data;
    } store_t;

    store_t st_r;
    store_t st_nxt;

    // ==================================================================
    // Field placement
    always_comb begin
        st_nxt = st_r;
        if (wr_in.valid) begin
            case (wr_in.kind)
                K_SLOT_LO: st_nxt.cfg[wr_in.port].slot_cap[15:0] = wr_in.data;
                K_SLOT_HI: st_nxt.cfg[wr_in.port].slot_cap[31:16] = wr_in.data;
                K_VEND_LO: st_nxt.cfg[wr_in.port].vendor_ctl[15:0] = wr_in.data;
                K_VEND_HI: st_nxt.cfg[wr_in.port].vendor_ctl[31:16] = wr_in.data;
                K_REPLAY: begin
                    st_nxt.cfg[wr_in.port].timer_csr[REPLAY_CNT_LSB +: REPLAY_CNT_W] =
                        wr_in.data[REPLAY_CNT_LSB +: REPLAY_CNT_W];
                    st_nxt.cfg[wr_in.port].timer_csr[REPLAY_USR_BIT] =
                        wr_in.data[REPLAY_USR_BIT];
                    st_nxt.cfg[wr_in.port].link_csr[TS_CSR_LSB +: TS_W] =
                        wr_in.data[TS_WORD_LSB +: TS_W];
                end
                K_ACK: begin
                    st_nxt.cfg[wr_in.port].timer_csr[ACK_CSR_LSB +: ACK_W] =
                        wr_in.data[ACK_WORD_LSB +: ACK_W];
                    st_nxt.cfg[wr_in.port].timer_csr[ACK_USR_CBIT] =
                        wr_in.data[ACK_USR_WBIT];
                end
                default: st_nxt.cfg = st_r.cfg;
            endcase
        end
        // Registered read keeps the bus path short
        if (rd_in.valid) begin
            case (rd_in.idx)
                2'h0:    st_nxt.rd_data = st_r.cfg[rd_in.port].slot_cap;
                2'h1:    st_nxt.rd_data = st_r.cfg[rd_in.port].vendor_ctl;
                2'h2:    st_nxt.rd_data = st_r.cfg[rd_in.port].timer_csr;
                default: st_nxt.rd_data = st_r.cfg[rd_in.port].link_csr;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            for (int p = 0; p < NPORT; p++) begin
                st_r.cfg[p] <= {SLOT_RST, VEND_RST, TIMER_RST, LINK_RST};
            end
            st_r.rd_data <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rd_data_out = st_r.rd_data;
    assign cfg_out     = st_r.cfg;

endmodule : port_field_store

//--- cfg_mem_model.sv
// Model of the serial configuration memory, delivering preload words.
// Assumes the bench fills addr_m/data_m/n_words before raising start_in.
module cfg_mem_model
    import preload_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       start_in,
    input  wire logic [1:0] gap_in,
    output preload_word_t   word_out,
    output logic            done_out,
    output logic            busy_out
);
    logic [7:0]  addr_m [32];
    logic [15:0] data_m [32];
    int          n_words = 0;
    int          idx;
    int          wait_cnt;

    // ==========================================================
    // Word delivery
    always @(posedge clk_in) begin
        if (!rst_b_in) begin
            idx <= 0;
            wait_cnt <= 0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            word_out <= '{1'b0, 8'h00, 16'hffff};
        end else if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            idx      <= 0;
            wait_cnt <= 0;
            done_out <= 1'b0;
            word_out <= '{1'b0, ~word_out.addr, ~word_out.data};
        end else if (busy_out && wait_cnt == 0 && idx < n_words) begin
            word_out <= '{1'b1, addr_m[idx], data_m[idx]};
            idx      <= idx + 1;
            wait_cnt <= int'(gap_in);
            done_out <= 1'b0;
        end else begin
            // Between words the bus wanders, so stale data never looks valid
            word_out <= '{1'b0, ~word_out.addr, ~word_out.data};
            wait_cnt <= (wait_cnt != 0) ? wait_cnt - 1 : 0;
            done_out <= busy_out && (wait_cnt == 0);
            busy_out <= busy_out && (wait_cnt != 0);
        end
    end
endmodule : cfg_mem_model

//--- tb_top.sv
// Self-checking bench for the per-port preload block.
// Assumes one-cycle word update and a two-cycle APB access phase.
module tb_top import preload_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] DEF_R = 12'h2a5;
    localparam logic [13:0] DEF_A = 14'h1b3c;
    localparam logic [7:0]  MAP [16] = '{8'h92, 8'h94, 8'ha2, 8'ha4, 8'hb0, 8'hb2, 8'hb4,
        8'hc0, 8'hc2, 8'hc4, 8'hd0, 8'hd2, 8'hd4, 8'he0, 8'he2, 8'hb0};
    logic                   clk = 1'b0;
    logic                   rst_b = 1'b0;
    logic                   start = 1'b0;
    logic [1:0]             gap = 2'h0;
    apb_req_t               req = '0;
    apb_rsp_t               rsp;
    preload_word_t          word;
    logic                   load_done;
    port_cfg_t [NPORT-1:0]  cfg;
    logic [NPORT-1:0][11:0] rep;
    logic [NPORT-1:0][13:0] ack;
    logic [NPORT-1:0]       lnk;
    logic [31:0]            e_img [NPORT][6];
    int                     e_cnt = 0;
    int                     error_cnt = 0;
    int                     checks_done = 0;
    logic [31:0]            rd;
    logic                   err;
    logic [15:0]            d;

    always #2.5 clk = ~clk;

    port_field_preload #(.DEF_REPLAY_LIMIT(DEF_R), .DEF_ACK_LATENCY(DEF_A)) DUT (
        .CLOCK_IN(clk), .RST_B_IN(rst_b), .WORD_IN(word), .LOAD_DONE_IN(load_done),
        .APB_REQ_IN(req), .APB_RSP_OUT(rsp), .PORT_CFG_OUT(cfg),
        .REPLAY_LIMIT_OUT(rep), .ACK_LATENCY_OUT(ack), .LINK_ENABLE_OUT(lnk));

    cfg_mem_model MEM (.clk_in(clk), .rst_b_in(rst_b), .start_in(start), .gap_in(gap),
        .word_out(word), .done_out(load_done), .busy_out());

    // ==========================================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, a, wd, 4'hf};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        rd = rsp.prdata;
        err = rsp.pslverr;
        if (n >= 20) chk(32'h0, 32'h1);
        req <= '0;
    endtask : apb

    // Queue a word in the memory and fold it into the expected images
    task automatic put(input int i, input logic [7:0] a, input logic [15:0] w, input bit live);
        int  p;
        bit  ok;
        p = int'(a[3:1]);
        MEM.addr_m[i] = a;
        MEM.data_m[i] = w;
        ok = live && !a[0] && (((a[7:4] == 4'h9 || a[7:4] == 4'ha) && p inside {1, 2})
            || (a[7:4] inside {4'hb, 4'hc, 4'hd} && p < 3) || (a[7:4] == 4'he && p < 2));
        if (ok) begin
            e_cnt++;
            case (a[7:4])
                4'h9: e_img[p][0][15:0] = w;
                4'ha: e_img[p][0][31:16] = w;
                4'hb: e_img[p][1][15:0] = w;
                4'hc: e_img[p][1][31:16] = w;
                4'hd: begin
                    e_img[p][2][12:0] = w[12:0];
                    e_img[p][3][25:24] = w[14:13];
                end
                default: e_img[p][2][30:16] = w[14:0];
            endcase
        end
        for (int q = 0; q < NPORT; q++) begin
            e_img[q][4] = {20'h0, e_img[q][2][12] ? e_img[q][2][11:0] : DEF_R};
            e_img[q][5] = {18'h0, e_img[q][2][30] ? e_img[q][2][29:16] : DEF_A};
        end
    endtask : put

    task automatic load(input int n);
        int t;
        MEM.n_words = n;
        gap <= 2'($urandom % 3);
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (load_done !== 1'b1 && t < 400);
        if (t >= 400) chk(32'h0, 32'h1);
        repeat (3) @(posedge clk);
    endtask : load

    task automatic check_all();
        for (int p = 0; p < NPORT; p++) begin
            chk(cfg[p].slot_cap, e_img[p][0]);
            chk(cfg[p].vendor_ctl, e_img[p][1]);
            chk(cfg[p].timer_csr, e_img[p][2]);
            chk(cfg[p].link_csr, e_img[p][3]);
            chk(32'(rep[p]), e_img[p][4]);
            chk(32'(ack[p]), e_img[p][5]);
        end
    endtask : check_all

    task automatic end_of_test();
        $display("comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================
    // Main sequence
    initial begin
        void'($urandom(39484));
        foreach (e_img[p, k]) e_img[p][k] = 32'h0;
        put(0, 8'h00, 16'h0, 1'b0);
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk);
        check_all();
        chk(32'(lnk), 32'h0);
        // Every mapped word, then an overwrite of B0h, then strays at E4h, odd and unmapped
        for (int i = 0; i < 16; i++) begin
            d = 16'($urandom);
            if (MAP[i] inside {8'hd0, 8'he0}) d = d | 16'h5000;
            if (MAP[i] inside {8'hd2, 8'he2}) d = d & 16'hafff;
            put(i, MAP[i], d, 1'b1);
        end
        put(16, 8'he4, 16'($urandom), 1'b1);
        put(17, 8'h93, 16'($urandom), 1'b1);
        put(18, 8'hf0, 16'($urandom), 1'b1);
        load(19);
        check_all();
        chk(32'(lnk), 32'h7);
        apb(1'b0, 12'h004, 32'h0);
        chk(32'(rd[0]), 32'h1);
        chk(32'(rd[15:8]), 32'(e_cnt));
        for (int p = 0; p < NPORT; p++) begin
            for (int k = 0; k < 6; k++) begin
                apb(1'b0, 12'(12'h100 + 32 * p + 4 * k), 32'h0);
                chk(rd, e_img[p][k]);
            end
        end
        apb(1'b0, 12'h0f0, 32'h0);
        chk(32'(err), 32'h1);
        // A word after completion must be refused
        put(0, 8'hb2, ~e_img[1][1][15:0], 1'b0);
        load(1);
        check_all();
        apb(1'b0, 12'h004, 32'h0);
        chk(32'(rd[2]), 32'h1);
        // Reload with links held off, then release the hold
        apb(1'b1, 12'h000, 32'h3);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, 12'h004, 32'h0);
        chk(32'(rd[0]), 32'h0);
        put(0, 8'hd4, 16'($urandom), 1'b1);
        load(1);
        check_all();
        chk(32'(lnk), 32'h0);
        apb(1'b1, 12'h000, 32'h0);
        repeat (3) @(posedge clk);
        chk(32'(lnk), 32'h7);
        end_of_test();
    end

    initial begin
        #50000;
        error_cnt++;
        end_of_test();
    end
endmodule : tb_top
